// File: pin_glue_pkg.sv
// Constants, register map and carrier types for the serial and parallel pin glue
package pin_glue_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned RST_PULSE_NS = 160;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TERM_HALF_NS = 4000;
  localparam int unsigned TERM_HALF_CYC = (TERM_HALF_NS * CLK_MHZ) / 1000;
  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_OUT_PORT = 8'h00;
  localparam logic [7:0] OFS_PA_DATA = 8'h04;
  localparam logic [7:0] OFS_PA_DIR = 8'h08;
  localparam logic [7:0] OFS_PB_DATA = 8'h0C;
  localparam logic [7:0] OFS_PB_DIR = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_PIN_IN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control bit positions
  localparam int CTL_RST_EN = 0;
  localparam int CTL_PA1_ROUTE = 1;
  localparam int CTL_PA5_ROUTE = 2;
  localparam int CTL_DCD_DAISY = 3;
  localparam int CTL_SYNC_A = 4;
  localparam int CTL_SYNC_B = 5;
  localparam int CTL_EXT_CLK_A = 6;
  localparam int CTL_W = 7;
  // Reset values
  localparam logic [7:0] OUT_PORT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [CTL_W-1:0] CTRL_RST = 7'h00;
  // ****************************************************************
  // Synchronised pin vector layout
  // ****************************************************************
  localparam int SI_TTX = 0;
  localparam int SI_MRX = 1;
  localparam int SI_MTC = 2;
  localparam int SI_MRC = 3;
  localparam int SI_XTC = 4;
  localparam int SI_CD = 5;
  localparam int SI_SYA = 6;
  localparam int SI_PA = 7;
  localparam int SI_PB = 15;
  localparam int SI_TC = 23;
  localparam int SI_TEN = 26;
  localparam int SYNC_W = 27;
  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] out_port;
    logic [7:0] pa_data;
    logic [7:0] pa_dir;
    logic [7:0] pb_data;
    logic [7:0] pb_dir;
    logic [CTL_W-1:0] ctrl;
    logic rst_flag;
  } regs_t;
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_t;
  typedef struct packed {
    logic a_tx_bit;
    logic b_tx_bit;
    logic a_sync_out;
    logic a_sync_oe;
    logic [1:0] irq_req;
  } ser_in_t;
  typedef struct packed {
    logic a_rx_bit;
    logic a_rx_stb;
    logic a_tx_stb;
    logic b_rx_bit;
    logic b_rx_stb;
    logic b_tx_stb;
    logic a_sync_in;
    logic a_dcd;
    logic a_dcd_chg;
    logic b_cts;
    logic b_cts_chg;
    logic b_dcd;
    logic b_dcd_chg;
    logic daisy_en;
  } ser_out_t;
  typedef struct packed {
    logic term_rx;
    logic modem_tx;
    logic sync_out;
    logic sync_oe;
    logic irq_oe;
    logic rst_n;
  } line_t;
  localparam ser_out_t SO_RST = '{a_rx_bit: 1'b1, b_rx_bit: 1'b1, a_dcd: 1'b1,
    b_cts: 1'b1, b_dcd: 1'b1, daisy_en: 1'b1, default: 1'b0};
  localparam line_t LINE_RST = '{term_rx: 1'b1, modem_tx: 1'b1, default: 1'b0};
endpackage : pin_glue_pkg

// File: pin_sync.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module pin_sync
  import pin_glue_pkg::*;
#(
  parameter int W = 1
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_ff, stab_ff, last_ff;
  logic [W-1:0] nxt_meta, nxt_stab, nxt_last;

  // Stage chain: the first stage feeds only the second
  always_comb
  begin
    nxt_meta = pin_in;
    nxt_stab = meta_ff;
    nxt_last = stab_ff;
  end

  // Register the chain; no reset, so it fills with the pin levels while
  // reset is held and an idle-high pin shows no false edge after release
  always_ff @(posedge ref_clk)
  begin
    meta_ff <= nxt_meta;
    stab_ff <= nxt_stab;
    last_ff <= nxt_last;
  end

  // Edges seen on the stable stage only, masked while the chain fills
  assign level = stab_ff;
  assign rise = stab_ff & ~last_ff & ~{W{sys_rst}};
  assign fall = ~stab_ff & last_ff & ~{W{sys_rst}};
endmodule : pin_sync

// File: pin_glue.sv
// Serial and parallel pin glue with AXI4-Lite register access
// Functional notes
// - Serial data lines: high is mark, low is space; idle and reset at mark.
// - Channel A serves terminal port: terminal_tx_in receives, terminal_rx_out transmits.
// - Channel B serves modem port: modem_tx_out transmits, modem_rx_in receives.
// - Sync modem transmit: output changes on falling edge of modem transmit clock.
// - Sync modem receive: sample modem_rx_in on rising edge of modem receive clock.
// - Drive terminal_tx_clk_out; rising edge samples received terminal data at bit centre.
// - Drive terminal_rx_clk_out; rising edge at centre of each transmitted terminal bit.
// - Terminal external clock mode: sample terminal_tx_in on its clock's rising edge.
// - Eight-bit fixed output port from one register, readback returns last written.
// - Parallel A bit 0 programmable as general input or output.
// - Parallel A bit 0 input rising edge with trigger enabled causes system reset.
// - Parallel A bit 1 input, when routed, feeds channel A carrier status.
// - Parallel A bit 5 input, when routed, feeds channel B CTS status.
// - Parallel B offers eight lines, each with its own direction.
// - Parallel B lines 6 and 7 pulled high when inputs, for straps.
// - Carrier detect pin feeds channel B DCD, or the daisy chain enable.
// - Sync A pin tied to channel A sync line, direction from channel.
// - Bit 0 triggered reset drives system_reset_out_n low, only when enabled.
// - Channel interrupts share one open-drain wired-OR request line.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module pin_glue
  import pin_glue_pkg::*;
#(
  parameter int TERM_HALF = TERM_HALF_CYC,
  parameter int RST_PULSE = RST_PULSE_CYC
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic terminal_tx_in,
  output logic terminal_rx_out,
  output logic modem_tx_out,
  input wire logic modem_rx_in,
  input wire logic modem_tx_clk_in,
  input wire logic modem_rx_clk_in,
  output logic terminal_tx_clk_out,
  output logic terminal_rx_clk_out,
  input wire logic terminal_ext_tx_clk_in,
  output logic [7:0] fixed_output_port,
  input wire logic [7:0] par_a_port_in,
  output logic [7:0] par_a_port_out,
  output logic [7:0] par_a_port_oe,
  input wire logic [7:0] par_b_port_in,
  output logic [7:0] par_b_port_out,
  output logic [7:0] par_b_port_oe,
  output logic [1:0] par_b_pullup_en,
  input wire logic carrier_detect_in,
  input wire logic sync_a_pin_in,
  output logic sync_a_pin_out,
  output logic sync_a_pin_oe,
  input wire logic [2:0] test_control_inputs,
  input wire logic test_enable_input,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic system_reset_out_n,
  input wire ser_in_t ser_in,
  output ser_out_t ser_out
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] pin_vec, lvl, rse, fll;
  assign pin_vec = {test_enable_input, test_control_inputs, par_b_port_in, par_a_port_in,
    sync_a_pin_in, carrier_detect_in, terminal_ext_tx_clk_in, modem_rx_clk_in,
    modem_tx_clk_in, modem_rx_in, terminal_tx_in};

  // Every pin input crosses two flops before any edge is taken
  pin_sync #(.W(SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(pin_vec),
    .level(lvl),
    .rise(rse),
    .fall(fll)
  );

  regs_t regs_ff, nxt_regs;
  bus_t bus_ff, nxt_bus;
  ser_out_t so_ff, nxt_so;
  line_t line_ff, nxt_line;
  logic [15:0] tcnt_ff, nxt_tcnt;
  logic tclk_ff, nxt_tclk;
  logic [15:0] rcnt_ff, nxt_rcnt;
  logic do_wr, ar_fire, t_wrap, t_rise, t_fall, rst_trig;
  logic sync_a, sync_b, ext_a, a_smp, a_launch, b_smp, b_launch;
  logic [31:0] pin_word;

  assign sync_a = regs_ff.ctrl[CTL_SYNC_A];
  assign sync_b = regs_ff.ctrl[CTL_SYNC_B];
  assign ext_a = regs_ff.ctrl[CTL_EXT_CLK_A];
  assign pin_word = {10'h000, lvl[SI_TEN:SI_TC], lvl[SI_SYA], lvl[SI_CD],
    lvl[SI_PB+7:SI_PB], lvl[SI_PA+7:SI_PA]};

  // ****************************************************************
  // Register access
  // ****************************************************************
  // Lane 0 merge for the byte-wide registers
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction : merge8

  // Known addresses
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    if (a == OFS_OUT_PORT || a == OFS_PA_DATA || a == OFS_PA_DIR || a == OFS_PB_DATA)
      addr_ok = 1'b1;
    else if (a == OFS_PB_DIR || a == OFS_CTRL || a == OFS_PIN_IN || a == OFS_STATUS)
      addr_ok = 1'b1;
    else
      addr_ok = 1'b0;
  endfunction : addr_ok

  // Read data multiplexer
  function automatic logic [31:0] rd_val(input logic [ADDR_W-1:0] a, input regs_t r,
                                         input logic [31:0] pw);
    if (a == OFS_OUT_PORT)
      rd_val = {24'h000000, r.out_port};
    else if (a == OFS_PA_DATA)
      rd_val = {24'h000000, r.pa_data};
    else if (a == OFS_PA_DIR)
      rd_val = {24'h000000, r.pa_dir};
    else if (a == OFS_PB_DATA)
      rd_val = {24'h000000, r.pb_data};
    else if (a == OFS_PB_DIR)
      rd_val = {24'h000000, r.pb_dir};
    else if (a == OFS_CTRL)
      rd_val = {25'h0000000, r.ctrl};
    else if (a == OFS_PIN_IN)
      rd_val = pw;
    else if (a == OFS_STATUS)
      rd_val = {31'h00000000, r.rst_flag};
    else
      rd_val = 32'h00000000;
  endfunction : rd_val

  assign do_wr = bus_ff.aw_got & bus_ff.w_got & ~bus_ff.bvalid;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign s_axi_awready = ~bus_ff.aw_got & ~bus_ff.bvalid;
  assign s_axi_wready = ~bus_ff.w_got & ~bus_ff.bvalid;
  assign s_axi_arready = ~bus_ff.rvalid;
  assign s_axi_bvalid = bus_ff.bvalid;
  assign s_axi_bresp = bus_ff.bresp;
  assign s_axi_rvalid = bus_ff.rvalid;
  assign s_axi_rdata = bus_ff.rdata;
  assign s_axi_rresp = bus_ff.rresp;

  // Channel handshakes: address and data taken in either order
  always_comb
  begin
    nxt_bus = bus_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_bus.aw_got = 1'b1;
      nxt_bus.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_bus.w_got = 1'b1;
      nxt_bus.wdata = s_axi_wdata;
      nxt_bus.wstrb = s_axi_wstrb;
    end
    if (do_wr)
    begin
      nxt_bus.aw_got = 1'b0;
      nxt_bus.w_got = 1'b0;
      nxt_bus.bvalid = 1'b1;
      nxt_bus.bresp = addr_ok(bus_ff.waddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bus_ff.bvalid && s_axi_bready)
      nxt_bus.bvalid = 1'b0;
    if (ar_fire)
    begin
      nxt_bus.rvalid = 1'b1;
      nxt_bus.rdata = rd_val(s_axi_araddr, regs_ff, pin_word);
      nxt_bus.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bus_ff.rvalid && s_axi_rready)
      nxt_bus.rvalid = 1'b0;
  end

  // Register writes; the reset event flag sets over a same-cycle clear
  always_comb
  begin
    nxt_regs = regs_ff;
    if (do_wr)
    begin
      if (bus_ff.waddr == OFS_OUT_PORT)
        nxt_regs.out_port = merge8(regs_ff.out_port, bus_ff.wdata, bus_ff.wstrb);
      else if (bus_ff.waddr == OFS_PA_DATA)
        nxt_regs.pa_data = merge8(regs_ff.pa_data, bus_ff.wdata, bus_ff.wstrb);
      else if (bus_ff.waddr == OFS_PA_DIR)
        nxt_regs.pa_dir = merge8(regs_ff.pa_dir, bus_ff.wdata, bus_ff.wstrb);
      else if (bus_ff.waddr == OFS_PB_DATA)
        nxt_regs.pb_data = merge8(regs_ff.pb_data, bus_ff.wdata, bus_ff.wstrb);
      else if (bus_ff.waddr == OFS_PB_DIR)
        nxt_regs.pb_dir = merge8(regs_ff.pb_dir, bus_ff.wdata, bus_ff.wstrb);
      else if (bus_ff.waddr == OFS_CTRL && bus_ff.wstrb[0])
        nxt_regs.ctrl = bus_ff.wdata[CTL_W-1:0];
      else if (bus_ff.waddr == OFS_STATUS && bus_ff.wstrb[0] && bus_ff.wdata[0])
        nxt_regs.rst_flag = 1'b0;
    end
    if (rst_trig)
      nxt_regs.rst_flag = 1'b1;
  end

  // Register bus and software state
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bus_ff <= '0;
      regs_ff <= '{out_port: OUT_PORT_RST, pa_data: DATA_RST, pa_dir: DIR_RST,
        pb_data: DATA_RST, pb_dir: DIR_RST, ctrl: CTRL_RST, rst_flag: 1'b0};
    end
    else
    begin
      bus_ff <= nxt_bus;
      regs_ff <= nxt_regs;
    end
  end

  // ****************************************************************
  // Terminal element clock divider
  // ****************************************************************
  assign t_wrap = (tcnt_ff == 16'(TERM_HALF - 1));
  assign t_rise = t_wrap & ~tclk_ff;
  assign t_fall = t_wrap & tclk_ff;

  // Free-running half-period counter
  always_comb
  begin
    nxt_tcnt = t_wrap ? 16'h0000 : tcnt_ff + 16'h0001;
    nxt_tclk = t_wrap ? ~tclk_ff : tclk_ff;
  end

  // Register the divider
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tcnt_ff <= 16'h0000;
      tclk_ff <= 1'b0;
    end
    else
    begin
      tcnt_ff <= nxt_tcnt;
      tclk_ff <= nxt_tclk;
    end
  end

  assign terminal_tx_clk_out = tclk_ff;
  assign terminal_rx_clk_out = tclk_ff;

  // ****************************************************************
  // Serial data paths and status routing
  // ****************************************************************
  assign a_smp = sync_a ? (ext_a ? rse[SI_XTC] : t_rise) : 1'b1;
  assign a_launch = sync_a ? t_fall : 1'b1;
  assign b_smp = sync_b ? rse[SI_MRC] : 1'b1;
  assign b_launch = sync_b ? fll[SI_MTC] : 1'b1;

  // Channel-side data, strobes and status lines
  always_comb
  begin
    nxt_so = so_ff;
    nxt_so.a_rx_stb = a_smp;
    nxt_so.a_tx_stb = a_launch;
    nxt_so.b_rx_stb = b_smp;
    nxt_so.b_tx_stb = b_launch;
    if (a_smp)
      nxt_so.a_rx_bit = lvl[SI_TTX];
    if (b_smp)
      nxt_so.b_rx_bit = lvl[SI_MRX];
    nxt_so.a_sync_in = lvl[SI_SYA];
    if (regs_ff.ctrl[CTL_PA1_ROUTE] && !regs_ff.pa_dir[1])
    begin
      nxt_so.a_dcd = lvl[SI_PA+1];
      nxt_so.a_dcd_chg = rse[SI_PA+1] | fll[SI_PA+1];
    end
    else
    begin
      nxt_so.a_dcd = 1'b1;
      nxt_so.a_dcd_chg = 1'b0;
    end
    if (regs_ff.ctrl[CTL_PA5_ROUTE] && !regs_ff.pa_dir[5])
    begin
      nxt_so.b_cts = lvl[SI_PA+5];
      nxt_so.b_cts_chg = rse[SI_PA+5] | fll[SI_PA+5];
    end
    else
    begin
      nxt_so.b_cts = 1'b1;
      nxt_so.b_cts_chg = 1'b0;
    end
    if (regs_ff.ctrl[CTL_DCD_DAISY])
    begin
      nxt_so.b_dcd = 1'b1;
      nxt_so.b_dcd_chg = 1'b0;
      nxt_so.daisy_en = lvl[SI_CD];
    end
    else
    begin
      nxt_so.b_dcd = lvl[SI_CD];
      nxt_so.b_dcd_chg = rse[SI_CD] | fll[SI_CD];
      nxt_so.daisy_en = 1'b1;
    end
  end

  // ****************************************************************
  // Line drivers and reset trigger
  // ****************************************************************
  assign rst_trig = regs_ff.ctrl[CTL_RST_EN] & ~regs_ff.pa_dir[0] & rse[SI_PA];

  // Pin-side drivers and the reset pulse counter
  always_comb
  begin
    nxt_line = line_ff;
    if (a_launch)
      nxt_line.term_rx = ser_in.a_tx_bit;
    if (b_launch)
      nxt_line.modem_tx = ser_in.b_tx_bit;
    nxt_line.sync_out = ser_in.a_sync_out;
    nxt_line.sync_oe = ser_in.a_sync_oe;
    nxt_line.irq_oe = |ser_in.irq_req;
    if (rst_trig)
      nxt_rcnt = 16'(RST_PULSE);
    else if (rcnt_ff != 16'h0000)
      nxt_rcnt = rcnt_ff - 16'h0001;
    else
      nxt_rcnt = 16'h0000;
    nxt_line.rst_n = (nxt_rcnt == 16'h0000);
  end

  // Register lines, channel side and counter
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      so_ff <= SO_RST;
      line_ff <= LINE_RST;
      rcnt_ff <= 16'h0000;
    end
    else
    begin
      so_ff <= nxt_so;
      line_ff <= nxt_line;
      rcnt_ff <= nxt_rcnt;
    end
  end

  assign ser_out = so_ff;
  assign terminal_rx_out = line_ff.term_rx;
  assign modem_tx_out = line_ff.modem_tx;
  assign sync_a_pin_out = line_ff.sync_out;
  assign sync_a_pin_oe = line_ff.sync_oe;
  assign irq_n_out = 1'b0;
  assign irq_n_oe = line_ff.irq_oe;
  assign system_reset_out_n = line_ff.rst_n;
  assign fixed_output_port = regs_ff.out_port;
  assign par_a_port_out = regs_ff.pa_data;
  assign par_a_port_oe = regs_ff.pa_dir;
  assign par_b_port_out = regs_ff.pb_data;
  assign par_b_port_oe = regs_ff.pb_dir;
  assign par_b_pullup_en = ~regs_ff.pb_dir[7:6];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_mark_reset: assert property (disable iff (1'b0)
    sys_rst |=> modem_tx_out && terminal_rx_out) else $error("lines not at mark after reset");
  a_term_launch: assert property (
    $changed(terminal_rx_out) && $past(sync_a) |-> $past(t_fall))
    else $error("terminal data moved off clock fall");
  a_modem_launch: assert property (
    $changed(modem_tx_out) && $past(sync_b) |-> $past(fll[SI_MTC]))
    else $error("modem data moved off clock fall");
  a_modem_sample: assert property (
    sync_b && rse[SI_MRC] |=> ser_out.b_rx_stb && ser_out.b_rx_bit == $past(lvl[SI_MRX]))
    else $error("modem receive sample missed");
  a_term_sample: assert property (
    $rose(terminal_tx_clk_out) && $past(sync_a && !ext_a) |-> ser_out.a_rx_stb)
    else $error("terminal sample not at clock rise");
  a_ext_sample: assert property (
    sync_a && ext_a && rse[SI_XTC] |=> ser_out.a_rx_stb && ser_out.a_rx_bit == $past(lvl[SI_TTX]))
    else $error("external clock sample missed");
  a_async_pass: assert property (
    !sync_a |=> terminal_rx_out == $past(ser_in.a_tx_bit)) else $error("async terminal tx lost");
  a_fixed_write: assert property (
    do_wr && bus_ff.waddr == OFS_OUT_PORT && bus_ff.wstrb[0]
    |=> fixed_output_port == $past(bus_ff.wdata[7:0])) else $error("fixed port not written");
  a_reset_pulse: assert property (
    rst_trig |=> (!system_reset_out_n)[*8]) else $error("reset pulse too short");
  a_reset_cause: assert property (
    $fell(system_reset_out_n) |-> $past(rst_trig)) else $error("reset without trigger");
  a_cts_route: assert property (
    regs_ff.ctrl[CTL_PA5_ROUTE] && !regs_ff.pa_dir[5] && rse[SI_PA+5] |=> ser_out.b_cts_chg)
    else $error("cts change not routed");
  a_irq_wired: assert property (
    |ser_in.irq_req |=> irq_n_oe && !irq_n_out) else $error("irq line not pulled");

  c_reset_trig: cover property (rst_trig ##1 !system_reset_out_n);
  c_modem_rx: cover property (sync_b && rse[SI_MRC] ##1 ser_out.b_rx_stb);
  c_ext_clk: cover property (sync_a && ext_a && rse[SI_XTC]);
  c_reg_write: cover property (do_wr ##1 s_axi_bvalid && s_axi_bready);
endmodule : pin_glue

// File: modem_model.sv
// Modem side model: receive clock and receive data toward the block
`timescale 1ns/1ps
module modem_model (
  output logic rx_clk,
  output logic rx_data
);
  // Idle at mark with the clock standing still
  initial
  begin
    rx_clk = 1'b0;
    rx_data = 1'b1;
  end
  // One byte lsb first; the clock runs only inside the frame
  task automatic send(input logic [7:0] b);
    #3;
    for (int i = 0; i < 8; i++)
    begin
      rx_data = b[i];
      #20 rx_clk = 1'b1;
      #40 rx_clk = 1'b0;
      #20;
    end
    rx_data = ~rx_data;
  endtask : send
endmodule : modem_model

// File: serial_and_parallel_pin_glue_tb.sv
// Self-checking bench for the serial and parallel pin glue
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module serial_and_parallel_pin_glue_tb
  import pin_glue_pkg::*;
;
  logic ref_clk = 1'b0, sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr, fixed_output_port, par_a_port_in, par_a_port_out;
  logic [7:0] par_a_port_oe, par_b_port_in, par_b_port_out, par_b_port_oe;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [2:0] test_control_inputs;
  logic [1:0] s_axi_bresp, s_axi_rresp, par_b_pullup_en;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, terminal_tx_in;
  logic terminal_rx_out, modem_tx_out, modem_rx_in, modem_tx_clk_in, modem_rx_clk_in;
  logic terminal_tx_clk_out, terminal_rx_clk_out, terminal_ext_tx_clk_in, carrier_detect_in;
  logic sync_a_pin_in, sync_a_pin_out, sync_a_pin_oe, test_enable_input, irq_n_out, irq_n_oe;
  logic system_reset_out_n;
  ser_in_t ser_in;
  ser_out_t ser_out;
  logic [7:0] ex [5];
  logic rxq [$];
  int seed = 4221, n_mismatch = 0, checks_done = 0, n, n_astb = 0;
  always #5 ref_clk = ~ref_clk;
  pin_glue #(.TERM_HALF(4), .RST_PULSE(8)) i_dut (.*);
  modem_model i_modem (.rx_clk(modem_rx_clk_in), .rx_data(modem_rx_in));
  // Collects bits handed over by the modem-side receiver
  always @(negedge ref_clk)
    if (ser_out.b_rx_stb === 1'b1) rxq.push_back(ser_out.b_rx_bit);
  // Counts channel A receive samples
  always @(negedge ref_clk)
    n_astb += (ser_out.a_rx_stb === 1'b1);
  // The modem times both directions with one element clock
  assign modem_tx_clk_in = modem_rx_clk_in;
  task automatic conclude;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic tmo;
    n_mismatch++;
    conclude();
  endtask : tmo
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  // ****************
  // Register bus
  // ****************
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n++ < 40)
    begin
      @(negedge ref_clk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      if (b) `CHK("bresp", er, s_axi_bresp)
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) tmo();
    @(posedge ref_clk);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    logic ar, r;
    n = 0;
    r = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && n++ < 40)
    begin
      @(negedge ref_clk);
      ar = s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge ref_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!r) tmo();
    @(posedge ref_clk);
  endtask : axr
  // Main sequence
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
      s_axi_arvalid, s_axi_rready, terminal_ext_tx_clk_in, ser_in} = '0;
    {test_control_inputs, test_enable_input} = '0;
    s_axi_wstrb = 4'hF;
    {par_a_port_in, par_b_port_in, terminal_tx_in, carrier_detect_in, sync_a_pin_in} = '1;
    tick(8);
    sys_rst <= 1'b0;
    tick(2);
    for (int i = 0; i < 5; i++)
    begin
      ex[i] = 8'($random(seed));
      axw(8'(i * 4), ex[i], RESP_OKAY);
    end
    axw(8'h40, 8'hFF, RESP_SLVERR);
    for (int i = 0; i < 5; i++)
    begin
      axr(8'(i * 4), rd);
      `CHK("readback", {24'h0, ex[i]}, rd)
    end
    `CHK("out port", ex[0], fixed_output_port)
    `CHK("pa out", ex[1], par_a_port_out)
    `CHK("pa oe", ex[2], par_a_port_oe)
    `CHK("pb out", ex[3], par_b_port_out)
    `CHK("pb oe", ex[4], par_b_port_oe)
    `CHK("pullup", ~ex[4][7:6], par_b_pullup_en)
    // Random channel-side and pin traffic
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      ser_in <= ser_in_t'(6'($random(seed)));
      terminal_tx_in <= 1'($random(seed));
      tick(4);
      @(negedge ref_clk);
      `CHK("term rx", ser_in.a_tx_bit, terminal_rx_out)
      `CHK("modem tx", ser_in.b_tx_bit, modem_tx_out)
      `CHK("a rx bit", terminal_tx_in, ser_out.a_rx_bit)
      `CHK("sync a", {ser_in.a_sync_out, ser_in.a_sync_oe}, {sync_a_pin_out, sync_a_pin_oe})
      `CHK("irq", {1'b0, |ser_in.irq_req}, {irq_n_out, irq_n_oe})
    end
    @(posedge ref_clk);
    // Terminal element clocks: external, then internal, one sample per rise
    axw(OFS_CTRL, 8'h50, RESP_OKAY);
    n_astb = 0;
    repeat (5)
    begin
      terminal_ext_tx_clk_in <= 1'b1;
      tick(4);
      terminal_ext_tx_clk_in <= 1'b0;
      tick(4);
    end
    `CHK("ext stb", 5, n_astb)
    axw(OFS_CTRL, 8'h10, RESP_OKAY);
    n_astb = 0;
    repeat (40)
    begin
      ser_in.a_tx_bit <= 1'($random(seed));
      tick(1);
    end
    `CHK("int stb", 40 / (2 * 4), n_astb)
    axw(OFS_PA_DIR, 8'h00, RESP_OKAY);
    axw(OFS_CTRL, 8'h06, RESP_OKAY);
    par_a_port_in <= 8'hDD;
    carrier_detect_in <= 1'b0;
    tick(5);
    @(negedge ref_clk);
    `CHK("a dcd", 1'b0, ser_out.a_dcd)
    `CHK("b cts", 1'b0, ser_out.b_cts)
    `CHK("b dcd", 1'b0, ser_out.b_dcd)
    @(posedge ref_clk);
    axw(OFS_CTRL, 8'h28, RESP_OKAY);
    @(negedge ref_clk);
    `CHK("daisy dcd", 1'b1, ser_out.b_dcd)
    `CHK("daisy en", 1'b0, ser_out.daisy_en)
    @(posedge ref_clk);
    axr(OFS_PIN_IN, rd);
    `CHK("pins in", {14'h0, 2'h2, 8'hFF, 8'hDD}, rd)
    rxq.delete();
    ex[0] = 8'($random(seed));
    ser_in.b_tx_bit <= ~ser_in.b_tx_bit;
    tick(4);
    @(negedge ref_clk);
    `CHK("modem hold", ~ser_in.b_tx_bit, modem_tx_out)
    i_modem.send(ex[0]);
    tick(6);
    `CHK("modem launch", ser_in.b_tx_bit, modem_tx_out)
    `CHK("rx count", 8, rxq.size())
    for (int i = 0; i < 8; i++) `CHK("rx bit", ex[0][i], rxq[i])
    axw(OFS_CTRL, 8'h01, RESP_OKAY);
    par_a_port_in <= 8'h00;
    tick(4);
    par_a_port_in <= 8'h01;
    n = 0;
    while (system_reset_out_n !== 1'b0 && n++ < 10) @(negedge ref_clk);
    if (n > 10) tmo();
    n = 0;
    while (system_reset_out_n === 1'b0 && n < 20) @(negedge ref_clk) n++;
    `CHK("reset pulse", 8, n)
    @(posedge ref_clk);
    axr(OFS_STATUS, rd);
    `CHK("rst flag", 32'h1, rd)
    axw(OFS_STATUS, 8'h01, RESP_OKAY);
    axr(OFS_STATUS, rd);
    `CHK("flag clear", 32'h0, rd)
    conclude();
  end
endmodule : serial_and_parallel_pin_glue_tb
